// [cbt_params.svh]
// Constants for the bus trace status encoder: offsets, fields, resets, times
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
// =====================================================================
// Register offsets (byte addresses)
`define CBT_CTRL_OFS 8'h00
`define CBT_QUAL_OFS 8'h04
`define CBT_STAT_OFS 8'h08
// =====================================================================
// Control fields
`define CBT_CTRL_HALTSEL 0
`define CBT_CTRL_RESTART 1
`define CBT_CTRL_DLY_LO 2
`define CBT_CTRL_DLY_HI 3
`define CBT_CTRL_WAITCARE 4
`define CBT_CTRL_WAITVAL 5
`define CBT_CTRL_T1CARE 6
`define CBT_CTRL_T1VAL 7
`define CBT_CTRL_RST 8'h58
`define CBT_QUAL_RST 16'h0000
// =====================================================================
// Times
`define CBT_CLK_NS 10
`define CBT_PULSE_NS 160
`define CBT_PULSE_CYC ((`CBT_PULSE_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`endif

// [cbt_pkg.sv]
// Types shared by the bus trace status encoder
package cbt_pkg;
  // Raw socket pins, sampled as one vector
  typedef struct packed {
    logic procClk;
    logic addrLatch;
    logic ready;
    logic [2:0] busStatus;
    logic [1:0] qs;
    logic upperByteEnB;
    logic lowestAddrBit;
    logic maskableInterruptInput;
    logic nmi;
    logic hlda;
    logic minMax;
    logic [1:0] rqgt;
    logic [15:0] data;
  } cbt_pins_s;
  // Byte validity code
  typedef enum logic [1:0] {BV_LOW, BV_ERR, BV_WORD, BV_HIGH} cbt_valid_e;
  // One stored cycle
  typedef struct packed {
    logic [15:0] data;
    logic [3:0] status;
    cbt_valid_e valid;
    logic [2:0] queueDepth;
    logic irq;
  } cbt_sample_s;
  typedef enum logic [2:0] {
    HALT_IDLE, HALT_REQ, HALT_WAIT, HALT_HELD, HALT_REL
  } cbt_halt_e;
endpackage : cbt_pkg

// [cbt_encoder.sv]
// Bus trace status encoder with AXI4-Lite control and halt sequencer
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cbt_params.svh"
module cbt_encoder
  import cbt_pkg::*;
#(
  parameter bit NARROW = 1'b0,
  parameter logic [2:0] MAXQ = NARROW ? 3'h4 : 3'h6
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire cbt_pins_s pins,
  input wire logic haltStrapEn,
  input wire logic trigIn,
  input wire logic acqFull,
  output cbt_sample_s sampleOut,
  output logic storeStrobe,
  output logic fetchFlagOut,
  output logic busGrantFlag,
  output logic rqgtOut,
  output logic rqgtOe,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int PW = $bits(cbt_pins_s);
  localparam logic [4:0] PULSE = 5'(`CBT_PULSE_CYC);

  // ===================================================================
  // Pin synchroniser
  logic [PW-1:0] s1_q, s2_q, s3_q, stab_q;
  cbt_pins_s p;
  assign p = cbt_pins_s'(stab_q);
  // A bit moves only once the last two stages agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stab_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= (s2_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
    end
  end

  // ===================================================================
  // Processor clock edges and bus state count
  logic clkPrev_q;
  logic [1:0] busState_q;
  wire clkFall = clkPrev_q & ~p.procClk;
  // Saturating fall count; the latch fall counts as one, so that
  // delay two meets the fall that ends the third bus state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clkPrev_q <= 1'b0;
      busState_q <= 2'h0;
    end else begin
      clkPrev_q <= p.procClk;
      if (clkFall && p.addrLatch)
        busState_q <= 2'h1;
      else if (clkFall && busState_q != 2'h3 && p.ready)
        busState_q <= busState_q + 2'h1;
    end
  end

  // ===================================================================
  // Status decode
  wire ifetch = (p.busStatus == 3'b100);
  wire rdWr = ~p.busStatus[1];
  wire memIo = p.busStatus[2];
  wire upperEn = NARROW ? 1'b0 : ~p.upperByteEnB;
  wire addrOdd = p.lowestAddrBit;
  wire isFirstState = p.addrLatch;
  wire isWait = ~p.ready;

  // ===================================================================
  // Queue tracking: depth, opcode history, flush
  logic [2:0] qDepth_q;
  logic [1:0] opHist_q;
  logic flushPend_q;
  // Fetch sizes: one byte at odd address or on the narrow bus
  wire fetchPoint = clkFall && ifetch && busState_q == 2'h2 && p.ready;
  wire [3:0] fetchAdd = (NARROW || addrOdd) ? 4'h1 : 4'h2;
  wire [3:0] qSum = {1'b0, qDepth_q} + (fetchPoint ? fetchAdd : 4'h0);
  wire execOne = p.qs[0];
  wire [3:0] qExec = (execOne && qSum != 4'h0) ? qSum - 4'h1 : qSum;
  wire [2:0] qNext = (qExec > {1'b0, MAXQ}) ? MAXQ : qExec[2:0];
  // Queue moves on each processor clock
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qDepth_q <= 3'h0;
      opHist_q <= 2'h0;
      flushPend_q <= 1'b0;
    end else if (clkFall) begin
      if (p.qs == 2'b10) begin
        qDepth_q <= 3'h0;
        opHist_q <= 2'h0;
        flushPend_q <= 1'b1;
      end else begin
        qDepth_q <= qNext;
        if (execOne)
          opHist_q <= {opHist_q[0], ~p.qs[1]};
        if (fetchPoint)
          flushPend_q <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Multiplexed status lines and byte validity
  wire [3:0] statusLines = ifetch ?
    {1'b1, opHist_q[1], opHist_q[0], flushPend_q} :
    {1'b0, memIo, rdWr, upperEn};
  wire cbt_valid_e fetchValid = addrOdd ? BV_HIGH : BV_WORD;
  wire cbt_valid_e dataValid = cbt_valid_e'({upperEn, addrOdd});
  // Narrow bus data lands in the lane of its address
  wire [15:0] laneData = !NARROW ? p.data :
    (addrOdd ? {p.data[7:0], 8'h00} : {8'h00, p.data[7:0]});

  // ===================================================================
  // Grant tracking per request/grant channel
  logic [1:0] rgPrev_q;
  logic [1:0] phase_q [2];
  logic [1:0] granted;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gCh
      // Each low pulse steps request, grant, release
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          // Matches the synchroniser's reset level: no false fall
          rgPrev_q[g] <= 1'b0;
          phase_q[g] <= 2'h0;
        end else begin
          rgPrev_q[g] <= p.rqgt[g];
          if (rgPrev_q[g] && !p.rqgt[g])
            phase_q[g] <= (phase_q[g] == 2'h2) ? 2'h0 : phase_q[g] + 2'h1;
        end
      end
      assign granted[g] = (phase_q[g] == 2'h2);
    end
  endgenerate
  wire grantNow = p.minMax ? p.hlda : |granted;

  // ===================================================================
  // Registers
  logic [7:0] ctrl_q;
  logic [15:0] qual_q;
  logic restart_q;
  logic strapEn_q, strapDone_q;
  wire [1:0] delaySet = ctrl_q[`CBT_CTRL_DLY_HI:`CBT_CTRL_DLY_LO];

  // ===================================================================
  // Storage qualification
  wire [5:0] qualLines = {isWait, isFirstState, grantNow, ifetch, grantNow,
                          p.minMax};
  wire qualOk = &(~qual_q[13:8] | ~(qualLines ^ qual_q[5:0]));
  wire synthOk =
    (!ctrl_q[`CBT_CTRL_WAITCARE] || isWait == ctrl_q[`CBT_CTRL_WAITVAL]) &&
    (!ctrl_q[`CBT_CTRL_T1CARE] || isFirstState == ctrl_q[`CBT_CTRL_T1VAL]);
  // Delay zero stores every clock; otherwise the counted bus state
  wire delayOk = (delaySet == 2'h0) ||
                 (busState_q == delaySet);
  wire storeNow = clkFall && delayOk && synthOk && qualOk;

  // Stored cycle: data, four status lines, validity, depth, request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sampleOut <= '0;
      storeStrobe <= 1'b0;
      fetchFlagOut <= 1'b0;
      busGrantFlag <= 1'b0;
    end else begin
      storeStrobe <= storeNow;
      fetchFlagOut <= ifetch;
      busGrantFlag <= grantNow;
      if (storeNow) begin
        sampleOut.data <= laneData;
        sampleOut.status <= statusLines;
        sampleOut.valid <= ifetch ? fetchValid : dataValid;
        sampleOut.queueDepth <= qDepth_q;
        sampleOut.irq <= p.maskableInterruptInput | p.nmi;
      end
    end
  end

  // ===================================================================
  // Strap capture after reset release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strapEn_q <= 1'b0;
      strapDone_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapEn_q <= haltStrapEn;
      strapDone_q <= 1'b1;
    end
  end

  // ===================================================================
  // Halt sequencer
  cbt_halt_e halt_q;
  logic [4:0] pulseCnt_q;
  logic trigSeen_q;
  wire haltOn = strapEn_q && ctrl_q[`CBT_CTRL_HALTSEL];
  wire driving = (halt_q == HALT_REQ) || (halt_q == HALT_REL);
  // Drives channel 0 low for one link period per pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      halt_q <= HALT_IDLE;
      pulseCnt_q <= 5'h0;
      trigSeen_q <= 1'b0;
      rqgtOe <= 1'b0;
      rqgtOut <= 1'b0;
    end else begin
      rqgtOe <= driving && pulseCnt_q != PULSE - 5'h1;
      rqgtOut <= 1'b0; // Open drain: we only ever pull the line low
      pulseCnt_q <= driving ? pulseCnt_q + 5'h1 : 5'h0;
      unique case (halt_q)
        HALT_IDLE: begin
          if (trigIn && haltOn)
            trigSeen_q <= 1'b1;
          if (trigSeen_q && acqFull && haltOn)
            halt_q <= HALT_REQ;
        end
        HALT_REQ:
          if (pulseCnt_q == PULSE - 5'h1)
            halt_q <= HALT_WAIT;
        // A locked sequence may hold off the grant for long
        HALT_WAIT:
          if (phase_q[0] == 2'h2)
            halt_q <= HALT_HELD;
        HALT_HELD:
          if (restart_q)
            halt_q <= HALT_REL;
        HALT_REL:
          if (pulseCnt_q == PULSE - 5'h1) begin
            halt_q <= HALT_IDLE;
            trigSeen_q <= 1'b0;
          end
        default:
          halt_q <= HALT_IDLE;
      endcase
    end
  end

  // ===================================================================
  // AXI4-Lite slave: address and data taken in either order
  logic awHave_q, wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  wire doWrite = awHave_q && wHave_q && !bvalid;
  wire wrCtrl = awAddr_q == `CBT_CTRL_OFS;
  wire wrQual = awAddr_q == `CBT_QUAL_OFS;
  wire wrOk = wrCtrl || wrQual || awAddr_q == `CBT_STAT_OFS;
  wire [31:0] statWord = {23'h0, halt_q, qDepth_q, strapEn_q,
                          busGrantFlag, trigSeen_q};
  wire rdOk = araddr == `CBT_CTRL_OFS || araddr == `CBT_QUAL_OFS ||
              araddr == `CBT_STAT_OFS;
  wire [31:0] rdMux = (araddr == `CBT_CTRL_OFS) ? {24'h0, ctrl_q} :
                      (araddr == `CBT_QUAL_OFS) ? {16'h0, qual_q} :
                      (araddr == `CBT_STAT_OFS) ? statWord : 32'h0;
  assign awready = !awHave_q;
  assign wready = !wHave_q;
  assign arready = !rvalid;

  // Write channels and register updates
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      ctrl_q <= `CBT_CTRL_RST;
      qual_q <= `CBT_QUAL_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (awvalid && !awHave_q) begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && !wHave_q) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrOk ? 2'b00 : 2'b11;
        if (wrCtrl && wStrb_q[0]) begin
          ctrl_q <= wData_q[7:0] & 8'hfd;
          restart_q <= wData_q[`CBT_CTRL_RESTART];
        end
        if (wrQual && wStrb_q[0])
          qual_q[7:0] <= wData_q[7:0] & 8'h3f;
        if (wrQual && wStrb_q[1])
          qual_q[15:8] <= wData_q[15:8] & 8'h3f;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'b00;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdOk ? 2'b00 : 2'b11;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : cbt_encoder
`default_nettype wire

// [cbt_proc_model.sv]
// Processor socket model: bus clock frames and grant answers
`timescale 1ns/1ns
`default_nettype none
module cbt_proc_model (
  input wire logic mclk,
  input wire logic rqgtOe,
  input wire logic [7:0] grantDly,
  output logic procClk,
  output logic addrLatch,
  output logic grantDrv
);
  logic held;
  // ==========================================================
  // Bus cycle of four states; clock stands low between frames
  task busCycle;
    for (int s = 0; s < 4; s++) begin
      addrLatch = (s == 0);
      procClk = 1'b1;
      #80;
      procClk = 1'b0;
      #80;
    end
    addrLatch = 1'b0;
  endtask : busCycle
  // ==========================================================
  // Our pulses alternate request and release; grant only after
  // a request, grantDly clocks after the request pulse ends
  initial begin
    procClk = 1'b0;
    addrLatch = 1'b0;
    grantDrv = 1'b0;
    held = 1'b0;
    forever begin
      @(posedge rqgtOe);
      @(negedge rqgtOe);
      if (!held) begin
        repeat (grantDly) @(posedge mclk);
        grantDrv <= 1'b1;
        repeat (16) @(posedge mclk);
        grantDrv <= 1'b0;
      end
      held = !held;
    end
  end
endmodule : cbt_proc_model
`default_nettype wire

// [cbt_encoder_chk.sv]
// Port checker for the bus trace status encoder
`timescale 1ns/1ns
`default_nettype none
module cbt_encoder_chk
  import cbt_pkg::*;
#(
  parameter logic [2:0] MAXQ = 3'h6
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire cbt_pins_s pins,
  input wire logic haltStrapEn,
  input wire cbt_sample_s sampleOut,
  input wire logic storeStrobe,
  input wire logic busGrantFlag,
  input wire logic rqgtOut,
  input wire logic rqgtOe,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Halt line: a pulse is 15 or 16 cycles of drive
  sequence sPulse;
    rqgtOe[*8] ##1 rqgtOe[*7];
  endsequence
  AST_PULSE: assert property ($rose(rqgtOe) |-> sPulse ##[1:2] !rqgtOe)
    else $error("halt pulse width wrong");
  AST_LOW: assert property (rqgtOe |-> !rqgtOut)
    else $error("halt line not driven low");
  AST_STRAP: assert property (!haltStrapEn |-> !rqgtOe)
    else $error("halt pulse without strap");
  AST_GRANT: assert property ((pins.minMax && pins.hlda)[*8] |-> busGrantFlag)
    else $error("grant flag missing");
  // ==========================================================
  // Trace stores
  AST_GAP: assert property (storeStrobe |=> !storeStrobe[*8])
    else $error("stores too close");
  AST_FETCH: assert property (storeStrobe && sampleOut.status[3] |->
    sampleOut.valid inside {BV_WORD, BV_HIGH})
    else $error("fetch byte validity wrong");
  AST_DEPTH: assert property (storeStrobe |-> sampleOut.queueDepth <= MAXQ)
    else $error("queue depth out of range");
  // ==========================================================
  // Register bus handshakes
  AST_BRESP: assert property (awvalid && awready && wvalid && wready |->
    ##[1:2] bvalid)
    else $error("write answer late");
  AST_BHOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  AST_RHOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  AST_DECERR: assert property (arvalid && arready && araddr > 8'h08 |=>
    rvalid && rresp == 2'b11 && rdata == 32'h0)
    else $error("unmapped read answer wrong");
endmodule : cbt_encoder_chk
bind cbt_encoder cbt_encoder_chk #(.MAXQ(MAXQ)) cbt_encoder_chk_i (.mclk,
  .rst_b, .pins, .haltStrapEn, .sampleOut, .storeStrobe, .busGrantFlag,
  .rqgtOut, .rqgtOe, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
`default_nettype wire

// [cbt_encoder_test.sv]
// Testbench for the bus trace status encoder
`timescale 1ns/1ns
`default_nettype none
module cbt_encoder_test
  import cbt_pkg::*;
;
  logic mclk = 1'b0, rst_b = 1'b0, haltStrapEn = 1'b1;
  logic trigIn = 1'b0, acqFull = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic storeStrobe, fetchFlagOut, busGrantFlag, rqgtOut, rqgtOe;
  logic procClk, addrLatch, grantDrv;
  cbt_sample_s sampleOut;
  cbt_pins_s base = '0;
  cbt_pins_s pinsW;
  int errTotal = 0, checks = 0, nStore = 0, n;
  always #5 mclk = ~mclk;
  // Request line is pulled up; either party may pull it low
  always_comb begin
    pinsW = base;
    pinsW.procClk = procClk;
    pinsW.addrLatch = addrLatch;
    pinsW.rqgt = {1'b1, ~((rqgtOe & ~rqgtOut) | grantDrv)};
  end
  always @(posedge mclk) if (storeStrobe === 1'b1) nStore++;
  cbt_encoder cbt_encoder_i (.mclk, .rst_b, .pins(pinsW), .haltStrapEn,
    .trigIn, .acqFull, .sampleOut, .storeStrobe, .fetchFlagOut,
    .busGrantFlag, .rqgtOut, .rqgtOe, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  cbt_proc_model cbt_proc_model_i (.mclk, .rqgtOe, .grantDly(8'd40),
    .procClk, .addrLatch, .grantDrv);
  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task axiWr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axiWr
  task axiRd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axiRd
  // Pins settle through the synchroniser before the frame runs
  task frame(input logic [2:0] st, input logic [1:0] q, input logic b, odd,
             input int k);
    @(posedge mclk);
    base.busStatus <= st;
    base.qs <= q;
    base.upperByteEnB <= b;
    base.lowestAddrBit <= odd;
    repeat (6) @(posedge mclk);
    nStore = 0;
    cbt_proc_model_i.busCycle();
    repeat (10) @(posedge mclk);
    chk(32'(nStore), 32'(k));
  endtask : frame
  task waitOe(input logic lvl);
    n = 0;
    while (rqgtOe !== lvl && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk(rqgtOe, lvl);
  endtask : waitOe
  task conclude;
    $display("checks %0d errors %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    errTotal++;
    conclude();
  end
  // ==========================================================
  // Test sequence
  initial begin
    base.ready = 1'b1;
    base.data = 16'hb4a5;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    axiRd(8'h00);
    chk(d, 32'h58);
    axiRd(8'h04);
    chk(d, 32'h0);
    axiRd(8'h0c);
    chk(d, 32'h0);
    chk(32'(r), 32'h3);
    axiWr(8'h10, 32'h1);
    chk(r, 2'b11);
    for (int i = 0; i < 4; i++) begin
      base.nmi <= i[0];
      base.maskableInterruptInput <= i[1];
      frame(i[0] ? 3'b010 : 3'b101, 2'b00, ~i[1], i[0], 1);
      chk({sampleOut.status[3:1], sampleOut.valid, sampleOut.irq},
          {1'b0, {2{~i[0]}}, i[1:0], |i[1:0]});
      chk(sampleOut.data, 16'hb4a5);
    end
    for (int i = 0; i < 2; i++) begin
      frame(3'b100, 2'b00, 1'b1, i[0], 1);
      chk({sampleOut.status[3], sampleOut.valid},
          {1'b1, i[0] ? BV_HIGH : BV_WORD});
    end
    frame(3'b100, 2'b10, 1'b1, 1'b0, 1);
    chk(sampleOut.status[0], 1'b1);
    axiWr(8'h04, 32'h0404);
    axiRd(8'h04);
    chk(d, 32'h0404);
    frame(3'b101, 2'b00, 1'b0, 1'b0, 0);
    frame(3'b100, 2'b00, 1'b1, 1'b0, 1);
    axiWr(8'h04, 32'h0);
    // Delay zero with no state qualifiers: every fall is stored
    axiWr(8'h00, 32'h0);
    frame(3'b101, 2'b00, 1'b0, 1'b0, 4);
    base.minMax <= 1'b1;
    base.hlda <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(busGrantFlag, 1'b1);
    base.minMax <= 1'b0;
    base.hlda <= 1'b0;
    axiWr(8'h00, 32'h59);
    trigIn <= 1'b1;
    @(posedge mclk);
    trigIn <= 1'b0;
    repeat (30) @(posedge mclk);
    chk(rqgtOe, 1'b0);
    acqFull <= 1'b1;
    waitOe(1'b1);
    waitOe(1'b0);
    n = 0;
    while (busGrantFlag !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk(busGrantFlag, 1'b1);
    acqFull <= 1'b0;
    repeat (30) @(posedge mclk);
    chk(rqgtOe, 1'b0);
    axiWr(8'h00, 32'h5b);
    waitOe(1'b1);
    waitOe(1'b0);
    rst_b <= 1'b0;
    haltStrapEn <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    axiWr(8'h00, 32'h59);
    trigIn <= 1'b1;
    acqFull <= 1'b1;
    repeat (60) @(posedge mclk);
    chk(rqgtOe, 1'b0);
    axiRd(8'h08);
    chk(d & 32'h4, 32'h0);
    conclude();
  end
endmodule : cbt_encoder_test
`default_nettype wire
